// [verilog/link_sideband_map.svh]
// constants for the link sideband status logic
// assumes a 25 MHz core clock
`ifndef LINK_SIDEBAND_MAP_SVH
`define LINK_SIDEBAND_MAP_SVH
`define CLK_HZ 25000000
`define BLINK_HALF_MS 250
`define BLINK_HALF_CYC ((`CLK_HZ / 1000) * `BLINK_HALF_MS)
`define POR_US 10
`define POR_CYC ((`CLK_HZ / 1000000) * `POR_US)
`define IDLE_MS 100
`define IDLE_CYC ((`CLK_HZ / 1000) * `IDLE_MS)
`define CNT_W 24
`endif

// [verilog/link_sideband_pkg.sv]
// types for the link sideband status logic
// shared by the main block, its checker and the testbench
package link_sideband_pkg;
    typedef enum logic [5:0] {
        ST_RESET    = 6'b000001,
        ST_SEARCH   = 6'b000010,
        ST_FULL     = 6'b000100,
        ST_DETACHED = 6'b001000,
        ST_LOW_POW  = 6'b010000,
        ST_IDLE     = 6'b100000
    } link_state_e;
endpackage

// [verilog/blink_timer.sv]
// free running blink generator, square wave of configurable half period
// assumes one clock; restarts while clear is high
`timescale 1ns/100ps
module blink_timer #(
    parameter int HALF_CYC = 1000
) (
    input wire logic clk, // core clock
    input wire logic rst_n, // sync reset, active low
    input wire logic clear, // hold blink low and restart
    output logic blink // square wave
);
    localparam int W = $clog2(HALF_CYC) + 1;
    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;
    logic blink_q;
    logic blink_d;

    always_comb
    begin
        cnt_d = cnt_q + 1'b1;
        blink_d = blink_q;
        if (clear)
        begin
            cnt_d = '0;
            blink_d = 1'b0;
        end
        else if (cnt_q == W'(HALF_CYC - 1))
        begin
            cnt_d = '0;
            blink_d = ~blink_q;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            cnt_q <= '0;
            blink_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            blink_q <= blink_d;
        end
    end

    assign blink = blink_q;
endmodule // blink_timer

// [verilog/link_sideband.sv]
// link state, indicator, mirror and power-sense forwarding of one transceiver end
// assumes pins are asynchronous; peer levels arrive already on this clock
//
// Functional notes
// - indicator stays low while powered down or held in reset
// - indicator blinks while searching for a peer
// - indicator steadily high once the link is established
// - mirror output low when no link exists
// - mirror output follows peer mirror input only in full speed state
// - mirror output blinks in the detached state
// - wake request forces full speed and blocks low power and idle states
// - standby hold input keeps the device in standby
// - internal power-on delay holds the reset state for POR_CYC cycles after external reset release
// - power states sequence automatically without host control
// - radio transmission off while in reset state
// - low power states track bus link suspend power profiles
// - upstream power sense forwarded; downstream side drives power enable
// - link only with complementary parity partner
`timescale 1ns/100ps
`include "link_sideband_map.svh"
module link_sideband #(
    parameter int BLINK_HALF_CYC = `BLINK_HALF_CYC,
    parameter int POR_CYC = `POR_CYC,
    parameter int IDLE_CYC = `IDLE_CYC
) (
    input wire logic clk, // core clock
    input wire logic rst_n, // sync reset, active low
    input wire logic standby_hold, // standby pin, high holds standby
    input wire logic remote_mirror_input, // local mirror pin, async
    input wire logic wake_request, // wake pin, async, active high
    input wire logic upstream_power_sense, // upstream bus power pin, async
    input wire logic own_parity, // strap: part parity, 0 even 1 odd
    input wire logic downstream_facing, // strap: this end faces downstream
    input wire logic peer_present, // radio sees a peer
    input wire logic peer_parity, // parity reported by peer
    input wire logic peer_mirror, // peer mirror level over the link
    input wire logic peer_power_sense, // peer upstream power over the link
    input wire logic link_traffic, // data moved this cycle
    input wire logic bus_suspend, // bus entered a suspend profile
    output link_sideband_pkg::link_state_e link_state, // power/link state
    output logic link_indicator_output, // indicator pin
    output logic remote_mirror_output, // mirror pin
    output logic downstream_power_enable, // downstream power switch
    output logic tx_mirror, // mirror level to send to peer
    output logic tx_power_sense, // power sense to send to peer
    output logic radio_enable // radio transmit allowed
);
    import link_sideband_pkg::*;

    // two-stage synchronisers for pins
    logic [3:0] pin_raw;
    logic [3:0] meta_q;
    logic [3:0] sync_q;
    assign pin_raw = {standby_hold, remote_mirror_input, wake_request, upstream_power_sense};
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_sync
            always_ff @(posedge clk)
            begin
                if (!rst_n)
                begin
                    meta_q[gi] <= 1'b0;
                    sync_q[gi] <= 1'b0;
                end
                else
                begin
                    meta_q[gi] <= pin_raw[gi];
                    sync_q[gi] <= meta_q[gi];
                end
            end
        end
    endgenerate
    logic hold_s;
    logic mirror_s;
    logic wake_s;
    logic power_s;
    assign hold_s = sync_q[3];
    assign mirror_s = sync_q[2];
    assign wake_s = sync_q[1];
    assign power_s = sync_q[0];

    // power-on reset: counts up after release, cleared only by the external rst_n
    logic por_done_q;
    logic por_done_d;
    logic [`CNT_W-1:0] por_cnt_q;
    logic [`CNT_W-1:0] por_cnt_d;
    logic [`CNT_W-1:0] idle_cnt_q;
    logic [`CNT_W-1:0] idle_cnt_d;
    link_state_e state_q;
    link_state_e state_d;
    logic partner_ok;
    logic in_reset;

    always_comb
    begin
        por_cnt_d = por_cnt_q;
        por_done_d = por_done_q;
        if (!por_done_q)
        begin
            if (por_cnt_q == `CNT_W'(POR_CYC - 1))
                por_done_d = 1'b1;
            else
                por_cnt_d = por_cnt_q + 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            por_cnt_q <= '0;
            por_done_q <= 1'b0;
        end
        else
        begin
            por_cnt_q <= por_cnt_d;
            por_done_q <= por_done_d;
        end
    end

    assign in_reset = !por_done_q || hold_s;
    assign partner_ok = peer_present && (peer_parity != own_parity);

    // autonomous power sequencing
    always_comb
    begin
        state_d = state_q;
        idle_cnt_d = idle_cnt_q;
        if (in_reset)
        begin
            state_d = ST_RESET;
            idle_cnt_d = '0;
        end
        else
        begin
            unique case (state_q)
                ST_RESET:
                    state_d = ST_SEARCH;
                ST_SEARCH:
                    if (partner_ok)
                    begin
                        state_d = ST_FULL;
                        idle_cnt_d = '0;
                    end
                ST_FULL:
                begin
                    if (link_traffic || wake_s)
                        idle_cnt_d = '0;
                    else if (idle_cnt_q != `CNT_W'(IDLE_CYC - 1))
                        idle_cnt_d = idle_cnt_q + 1'b1;
                    if (!partner_ok)
                        state_d = ST_SEARCH;
                    else if (wake_s)
                        state_d = ST_FULL;
                    else if (bus_suspend)
                        state_d = ST_LOW_POW;
                    else if (idle_cnt_q == `CNT_W'(IDLE_CYC - 1))
                        state_d = ST_DETACHED;
                end
                ST_DETACHED:
                    if (!partner_ok)
                        state_d = ST_SEARCH;
                    else if (wake_s || link_traffic)
                    begin
                        state_d = ST_FULL;
                        idle_cnt_d = '0;
                    end
                    else if (bus_suspend)
                        state_d = ST_IDLE;
                ST_LOW_POW, ST_IDLE:
                    if (!partner_ok)
                        state_d = ST_SEARCH;
                    else if (wake_s || !bus_suspend || link_traffic)
                    begin
                        state_d = ST_FULL;
                        idle_cnt_d = '0;
                    end
                default:
                    state_d = ST_RESET;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_q <= ST_RESET;
            idle_cnt_q <= '0;
        end
        else
        begin
            state_q <= state_d;
            idle_cnt_q <= idle_cnt_d;
        end
    end

    // one timer serves both outputs; they never blink at once
    logic blink;
    blink_timer #(
        .HALF_CYC(BLINK_HALF_CYC)
    ) u_blink (
        .clk(clk),
        .rst_n(rst_n),
        .clear(state_q == ST_RESET),
        .blink(blink)
    );

    // registered outputs
    logic led_d;
    logic led_q;
    logic mir_d;
    logic mir_q;
    logic den_d;
    logic den_q;
    logic radio_d;
    logic radio_q;
    logic txm_q;
    logic txp_q;

    always_comb
    begin
        led_d = 1'b0;
        mir_d = 1'b0;
        den_d = 1'b0;
        radio_d = 1'b0;
        unique case (state_d)
            ST_RESET:
                led_d = 1'b0;
            ST_SEARCH:
            begin
                led_d = blink;
                radio_d = 1'b1;
            end
            ST_FULL:
            begin
                led_d = 1'b1;
                mir_d = peer_mirror;
                radio_d = 1'b1;
            end
            ST_DETACHED:
            begin
                led_d = 1'b1;
                mir_d = blink;
                radio_d = 1'b1;
            end
            ST_LOW_POW, ST_IDLE:
            begin
                led_d = 1'b1;
                radio_d = 1'b1;
            end
            default:
                led_d = 1'b0;
        endcase
        // enumeration waits for link, so gate on link states only
        if (downstream_facing && state_d != ST_RESET && state_d != ST_SEARCH)
            den_d = peer_power_sense;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            led_q <= 1'b0;
            mir_q <= 1'b0;
            den_q <= 1'b0;
            radio_q <= 1'b0;
            txm_q <= 1'b0;
            txp_q <= 1'b0;
        end
        else
        begin
            led_q <= led_d;
            mir_q <= mir_d;
            den_q <= den_d;
            radio_q <= radio_d;
            txm_q <= mirror_s;
            txp_q <= power_s && !downstream_facing;
        end
    end

    assign link_state = state_q;
    assign link_indicator_output = led_q;
    assign remote_mirror_output = mir_q;
    assign downstream_power_enable = den_q;
    assign radio_enable = radio_q;
    assign tx_mirror = txm_q;
    assign tx_power_sense = txp_q;
endmodule // link_sideband

// [tb/peer_model.sv]
// peer transceiver across the link, one register hop like the radio
// assumes the bench commands presence, parity, mirror and power levels
`timescale 1ns/100ps
module peer_model (
    input wire logic clk, // core clock
    input wire logic present_cmd, // peer in range
    input wire logic odd_cmd, // peer part parity
    input wire logic mirror_cmd, // peer mirror pin, may carry wake interrupt
    input wire logic power_cmd, // peer upstream power sense
    output logic peer_present, // seen by radio
    output logic peer_parity, // reported parity
    output logic peer_mirror, // mirror level over link
    output logic peer_power_sense // power over link
);
    logic [3:0] hop_d;
    logic [3:0] hop_q = 4'h0;
    always_comb hop_d = {present_cmd, odd_cmd, mirror_cmd, power_cmd};
    always_ff @(posedge clk) hop_q <= hop_d;
    assign {peer_present, peer_parity, peer_mirror, peer_power_sense} = hop_q;
endmodule // peer_model

// [tb/link_sideband_chk.sv]
// assertions on the link sideband ports, bound into the block
// assumes one clock and the synchronous active-low reset
`timescale 1ns/100ps
module link_sideband_chk
    import link_sideband_pkg::*;
#(
    parameter int BLINK_HALF_CYC = 4
) (
    input wire logic clk, // core clock
    input wire logic rst_n, // sync reset
    input wire logic standby_hold, // standby pin
    input wire logic remote_mirror_input, // mirror pin in
    input wire logic wake_request, // wake pin
    input wire logic own_parity, // strap
    input wire logic downstream_facing, // strap
    input wire logic peer_parity, // peer parity
    input wire logic peer_mirror, // peer mirror
    input wire link_state_e link_state, // state
    input wire logic link_indicator_output, // indicator
    input wire logic remote_mirror_output, // mirror pin out
    input wire logic downstream_power_enable, // power switch
    input wire logic tx_mirror, // mirror to peer
    input wire logic radio_enable // radio on
);
    logic [7:0] run_d;
    logic [7:0] run_q;
    logic watch;
    logic watch_q;
    link_state_e st_q;
    // stable-run length of the blinking output, must stay short
    always_comb
    begin
        watch = (link_state == ST_SEARCH) ? link_indicator_output : remote_mirror_output;
        run_d = 8'h00;
        if (link_state inside {ST_SEARCH, ST_DETACHED} && link_state == st_q && watch == watch_q)
            run_d = run_q + 8'h01;
    end
    always_ff @(posedge clk)
    begin
        run_q <= rst_n ? run_d : 8'h00;
        st_q <= link_state;
        watch_q <= watch;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // pin levels held long enough to pass the synchroniser and settle the state
    sequence s_wake_held;
        wake_request [*5];
    endsequence
    sequence s_standby_held;
        standby_hold [*4];
    endsequence
    a_reset_quiet: assert property (link_state == ST_RESET |-> !link_indicator_output && !radio_enable)
        else $error("output active in reset state");
    a_full_steady: assert property (link_state == ST_FULL |-> link_indicator_output)
        else $error("indicator low with link up");
    a_full_mirror: assert property (link_state == ST_FULL |-> remote_mirror_output == $past(peer_mirror))
        else $error("mirror not following peer");
    a_search_mirror: assert property (link_state == ST_SEARCH |-> !remote_mirror_output)
        else $error("mirror high without link");
    a_blink_runs: assert property (run_q <= BLINK_HALF_CYC + 1)
        else $error("blink stalled");
    a_wake_held: assert property (s_wake_held |-> !(link_state inside {ST_DETACHED, ST_LOW_POW, ST_IDLE}))
        else $error("wake did not hold full speed");
    a_standby_held: assert property (s_standby_held |-> link_state == ST_RESET)
        else $error("standby not holding reset");
    a_sleep_outputs: assert property (link_state inside {ST_LOW_POW, ST_IDLE} |-> link_indicator_output && !remote_mirror_output)
        else $error("wrong outputs in low power state");
    a_parity_refused: assert property (link_state == ST_SEARCH && peer_parity == own_parity |=> link_state != ST_FULL)
        else $error("linked to same parity");
    a_power_gate: assert property (!$past(downstream_facing) |-> !downstream_power_enable)
        else $error("power enable on upstream end");
    a_mirror_sync: assert property ($past(rst_n, 3) && $past(rst_n, 2) && $past(rst_n)
        |-> tx_mirror == $past(remote_mirror_input, 3))
        else $error("mirror forward latency wrong");
endmodule // link_sideband_chk
bind link_sideband link_sideband_chk #(.BLINK_HALF_CYC(BLINK_HALF_CYC)) u_link_sideband_chk (
    .clk(clk), .rst_n(rst_n), .standby_hold(standby_hold), .remote_mirror_input(remote_mirror_input),
    .wake_request(wake_request), .own_parity(own_parity), .downstream_facing(downstream_facing),
    .peer_parity(peer_parity), .peer_mirror(peer_mirror), .link_state(link_state),
    .link_indicator_output(link_indicator_output), .remote_mirror_output(remote_mirror_output),
    .downstream_power_enable(downstream_power_enable), .tx_mirror(tx_mirror), .radio_enable(radio_enable)
);

// [tb/testbench.sv]
// self-checking bench for the link sideband block with a peer model
// assumes short test counts so every state is reached quickly
`timescale 1ns/100ps
module testbench;
    import link_sideband_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic sb = 1'b0, mir_in = 1'b0, wake = 1'b0, ups = 1'b1, odd = 1'b0, dsf = 1'b1;
    logic p_on = 1'b0, p_odd = 1'b0, p_mir = 1'b0, p_pwr = 1'b0, traffic = 1'b0, susp = 1'b0;
    logic pres, ppar, pmir, ppwr, ind, mir_out, pwr_en, txm, txp, radio;
    link_state_e st;
    int bad_count = 0;
    int n_checks = 0;
    int n;
    initial forever #20 clk = ~clk;
    peer_model u_peer_model (.clk(clk), .present_cmd(p_on), .odd_cmd(p_odd), .mirror_cmd(p_mir),
        .power_cmd(p_pwr), .peer_present(pres), .peer_parity(ppar), .peer_mirror(pmir), .peer_power_sense(ppwr));
    link_sideband #(.BLINK_HALF_CYC(4), .POR_CYC(4), .IDLE_CYC(8)) u_link_sideband (.clk(clk), .rst_n(rst_n),
        .standby_hold(sb), .remote_mirror_input(mir_in), .wake_request(wake), .upstream_power_sense(ups),
        .own_parity(odd), .downstream_facing(dsf), .peer_present(pres), .peer_parity(ppar), .peer_mirror(pmir),
        .peer_power_sense(ppwr), .link_traffic(traffic), .bus_suspend(susp), .link_state(st),
        .link_indicator_output(ind), .remote_mirror_output(mir_out), .downstream_power_enable(pwr_en),
        .tx_mirror(txm), .tx_power_sense(txp), .radio_enable(radio));
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [5:0] got, input logic [5:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wait_st(input link_state_e s);
        for (int i = 0; i < 60 && st !== s; i++)
            @(negedge clk);
        chk(st, s);
        if (st !== s)
            finish_test();
    endtask
    // counts level changes over three blink half periods
    task automatic toggles(input bit use_ind);
        logic last;
        n = 0;
        last = use_ind ? ind : mir_out;
        repeat (12)
        begin
            @(negedge clk);
            if ((use_ind ? ind : mir_out) !== last)
                n++;
            last = use_ind ? ind : mir_out;
        end
    endtask
    task automatic t_por;
        @(negedge clk);
        chk({st == ST_RESET, ind, radio}, 6'h04);
        wait_st(ST_SEARCH);
        chk(radio, 6'h01);
    endtask
    task automatic t_search;
        toggles(1'b1);
        chk(n >= 2, 6'h01);
        chk(mir_out, 6'h00);
        @(posedge clk);
        p_on <= 1'b1;
        repeat (10) @(negedge clk);
        chk(st, ST_SEARCH);
    endtask
    task automatic t_link;
        @(posedge clk);
        p_odd <= 1'b1;
        p_pwr <= 1'b1;
        traffic <= 1'b1;
        mir_in <= 1'b1;
        wait_st(ST_FULL);
        repeat (3) @(negedge clk);
        chk({ind, pwr_en, txp, txm}, 6'h0D);
        for (int v = 1; v >= 0; v--)
        begin
            @(posedge clk);
            p_mir <= v[0];
            repeat (3) @(negedge clk);
            chk(mir_out, v[0]);
        end
    endtask
    task automatic t_idle_wake;
        @(posedge clk);
        traffic <= 1'b0;
        wait_st(ST_DETACHED);
        toggles(1'b0);
        chk(n >= 2, 6'h01);
        @(posedge clk);
        wake <= 1'b1;
        p_mir <= 1'b1;
        wait_st(ST_FULL);
        @(posedge clk);
        susp <= 1'b1;
        repeat (12) @(negedge clk);
        chk(st, ST_FULL);
        @(posedge clk);
        wake <= 1'b0;
        wait_st(ST_LOW_POW);
        chk(mir_out, 6'h00);
    endtask
    task automatic t_standby;
        @(posedge clk);
        sb <= 1'b1;
        wait_st(ST_RESET);
        repeat (10) @(negedge clk);
        chk({st == ST_RESET, ind, radio}, 6'h04);
        @(posedge clk);
        sb <= 1'b0;
        susp <= 1'b0;
        wait_st(ST_FULL);
        @(posedge clk);
        p_on <= 1'b0;
        wait_st(ST_SEARCH);
        repeat (2) @(negedge clk);
        chk(pwr_en, 6'h00);
    endtask
    // relink, let the link go detached, then suspend into idle and wake out of it
    task automatic t_idle_state;
        @(posedge clk);
        p_on <= 1'b1;
        wait_st(ST_FULL);
        wait_st(ST_DETACHED);
        @(posedge clk);
        susp <= 1'b1;
        wait_st(ST_IDLE);
        chk({ind, mir_out, radio}, 6'h05);
        @(posedge clk);
        wake <= 1'b1;
        wait_st(ST_FULL);
        @(posedge clk);
        wake <= 1'b0;
        susp <= 1'b0;
    endtask
    // upstream facing end: forwards its power sense, never drives the enable
    task automatic t_upstream;
        @(posedge clk);
        dsf <= 1'b0;
        repeat (2) @(negedge clk);
        chk({pwr_en, txp}, 6'h01);
        @(posedge clk);
        ups <= 1'b0;
        repeat (4) @(negedge clk);
        chk(txp, 6'h00);
    endtask
    initial
    begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        t_por();
        t_search();
        t_link();
        t_idle_wake();
        t_standby();
        t_idle_state();
        t_upstream();
        finish_test();
    end
endmodule // testbench
